// [src/fsc_params.svh]
/*
 * Constants of the flash status / configuration register block: opcodes,
 * register-select addresses, bit positions and reset values.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef FSC_PARAMS_SVH
`define FSC_PARAMS_SVH

// Opcodes
`define FSC_OP_RD_SR2        8'h07
`define FSC_OP_RD_ANY        8'h65
`define FSC_OP_WR_REGS       8'h01
`define FSC_OP_WR_ANY        8'h71

// Register-select addresses for the any-register commands
`define FSC_ADDR_STAT1       24'h800000
`define FSC_ADDR_STAT2       24'h800001
`define FSC_ADDR_CFG1        24'h000002

// Second status register bits
`define FSC_SR2_ERASE_RESULT 2
`define FSC_SR2_ERASE_SUSP   1
`define FSC_SR2_PROG_SUSP    0
`define FSC_SR2_RESET        8'h00

// Configuration register bits
`define FSC_CR1_TBPROT       5
`define FSC_CR1_BPNV         3
`define FSC_CR1_TBPARM       2
`define FSC_CR1_QUAD         1
`define FSC_CR1_FREEZE       0
`define FSC_CR1_RESET        8'h00

// Block-protect field in the first status register
`define FSC_SR1_BP_HI        4
`define FSC_SR1_BP_LO        2
`define FSC_BP_RESET         3'h0

// Whole array in sixty-fourths
`define FSC_WHOLE_64THS      7'h40

`endif

// [src/fsc_pkg.sv]
/*
 * Types of the flash status / configuration register block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package fsc_pkg;

	typedef enum logic [4:0] {
		FSC_ST_CMD    = 5'b00001,
		FSC_ST_ADDR   = 5'b00010,
		FSC_ST_READ   = 5'b00100,
		FSC_ST_WDATA  = 5'b01000,
		FSC_ST_IGNORE = 5'b10000
	} fsc_state_t;

endpackage

// [src/fsc_sync.sv]
/*
 * Two flip-flop synchroniser for one level.
 * Assumes the input is asynchronous to mclk; only the second stage is read.
 */
`timescale 1ns/1ps

module fsc_sync #(
	parameter logic RESET_VAL = 1'b0
) (
	// Clock and reset
	input  wire logic mclk,
	input  wire logic nrst,
	// Level in and out
	input  wire logic async_in,
	output logic      sync_out
);

	logic meta_r;

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			meta_r   <= RESET_VAL;
			sync_out <= RESET_VAL;
		end else begin
			meta_r   <= async_in;
			sync_out <= meta_r;
		end
	end

endmodule

// [src/fsc_regs.sv]
/*
 * Serial-bus slave holding the second status register and the non-volatile
 * configuration register, plus the block-protect bits that the write-registers
 * command also carries.
 * Assumes mode-0 serial timing (sample on sck rise, drive on sck fall), sck
 * well below mclk/4, and core status inputs on the mclk domain.
 */
// Notes on behaviour
// - Second status register is read by opcode 07h or read-any-register 65h.
// - Second status bits are read-only hardware status; bits 7-3 read 0; reset 0.
// - Erase-result bit shows 1 when the checked sector's last erase completed.
// - Erase-result bit is not valid while program or erase is suspended.
// - Bit 1 shows erase suspend; user writes cannot change it.
// - Bit 0 shows program suspend; user writes cannot change it.
// - Configuration written by write-registers with sixteen data cycles or write-any-register.
// - Protection-start bit 0 protects from top, 1 from bottom.
// - Protection-start bit is one-time programmable and ships as 0.
// - Writing 0 to a programmed one-time bit changes nothing, raises no error.
// - Bit 3 one-time: 1 makes block-protect bits volatile, 0 non-volatile.
// - One-time bit 2 puts parameter sectors high when 1, low when 0.
// - Bit 1 is the power-up default of the volatile quad-width bit, ships 0.
// - Bit 0 is the freeze default; read-only, reads 0.
// - Block-protect bits select one sixty-fourth up to the whole array.
// - With volatility bit 1, write-registers updates only volatile protect bits.
`timescale 1ns/1ps
`include "fsc_params.svh"

module fsc_regs (
	// Clock and reset
	input  wire logic       mclk,
	input  wire logic       nrst,
	// Serial pins
	input  wire logic       sck,
	input  wire logic       cs_n,
	input  wire logic       si,
	output logic            so_out,
	output logic            so_oe,
	// Device core status
	input  wire logic       write_enable_latch,
	input  wire logic       erase_check_done,
	input  wire logic       erase_check_pass,
	input  wire logic       erase_suspended_bit,
	input  wire logic       program_suspended_bit,
	// Configuration to the core
	output logic            protect_start_otp,
	output logic            protect_volatility_otp,
	output logic            param_sector_place_otp,
	output logic            wide_io_default,
	output logic            freeze_default,
	output logic [2:0]      block_protect_bits,
	output logic [2:0]      block_protect_nv_bits,
	output logic [6:0]      protected_64ths,
	output logic            protect_from_bottom,
	output logic            reg_write_done
);

	// Synchronised pins
	logic sck_s;
	logic cs_n_s;
	logic si_s;
	logic sck_d_r;
	logic cs_n_d_r;

	fsc_sync #(.RESET_VAL(1'b0)) u_sync_sck (
		.mclk     (mclk),
		.nrst     (nrst),
		.async_in (sck),
		.sync_out (sck_s)
	);

	fsc_sync #(.RESET_VAL(1'b1)) u_sync_cs (
		.mclk     (mclk),
		.nrst     (nrst),
		.async_in (cs_n),
		.sync_out (cs_n_s)
	);

	fsc_sync #(.RESET_VAL(1'b0)) u_sync_si (
		.mclk     (mclk),
		.nrst     (nrst),
		.async_in (si),
		.sync_out (si_s)
	);

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			sck_d_r  <= 1'b0;
			cs_n_d_r <= 1'b1;
		end else begin
			sck_d_r  <= sck_s;
			cs_n_d_r <= cs_n_s;
		end
	end

	wire sck_rise  = sck_s & ~sck_d_r & ~cs_n_s;
	wire sck_fall  = ~sck_s & sck_d_r & ~cs_n_s;
	wire cs_start  = ~cs_n_s & cs_n_d_r;
	wire cs_end    = cs_n_s & ~cs_n_d_r;

	// Frame state
	fsc_pkg::fsc_state_t state_r;
	fsc_pkg::fsc_state_t state_nxt;
	logic [2:0]  bit_cnt_r;
	logic [6:0]  shift_in_r;
	logic [1:0]  byte_cnt_r;
	logic [23:0] addr_r;
	logic        is_any_r;
	logic [7:0]  data0_r;
	logic [7:0]  data1_r;
	logic [1:0]  data_cnt_r;
	logic [7:0]  out_shift_r;

	// Register contents
	logic       erase_result_r;
	logic       tbprot_r;
	logic       bpnv_r;
	logic       tbparm_r;
	logic       quad_r;
	logic [2:0] bp_v_r;
	logic [2:0] bp_nv_r;
	logic       init_done_r;

	wire       byte_done = sck_rise & (bit_cnt_r == 3'd7);
	wire [7:0] byte_in   = {shift_in_r, si_s};
	wire [23:0] addr_full = {addr_r[15:0], byte_in};

	// Register images seen by readers
	wire suspended = erase_suspended_bit | program_suspended_bit;
	wire [7:0] sr2_img = {5'h00,
		erase_result_r & ~suspended,
		erase_suspended_bit,
		program_suspended_bit};
	wire [7:0] cr1_img = {2'b00, tbprot_r, 1'b0, bpnv_r, tbparm_r, quad_r, 1'b0};
	wire [7:0] sr1_bp_img = {3'b000, bp_v_r, 2'b00};

	// Read-any-register source selection
	wire [7:0] any_img_new =
		(addr_full == `FSC_ADDR_STAT2) ? sr2_img :
		(addr_full == `FSC_ADDR_CFG1)  ? cr1_img :
		(addr_full == `FSC_ADDR_STAT1) ? sr1_bp_img : 8'h00;
	wire [7:0] any_img_cur =
		(addr_r == `FSC_ADDR_STAT2) ? sr2_img :
		(addr_r == `FSC_ADDR_CFG1)  ? cr1_img :
		(addr_r == `FSC_ADDR_STAT1) ? sr1_bp_img : 8'h00;
	wire [7:0] repeat_img = is_any_r ? any_img_cur : sr2_img;

	// Next state on a completed byte
	always_comb begin
		state_nxt = state_r;
		if (byte_done) begin
			case (state_r)
				fsc_pkg::FSC_ST_CMD: begin
					if (byte_in == `FSC_OP_RD_SR2)
						state_nxt = fsc_pkg::FSC_ST_READ;
					else if (byte_in == `FSC_OP_RD_ANY)
						state_nxt = fsc_pkg::FSC_ST_ADDR;
					else if (byte_in == `FSC_OP_WR_REGS && write_enable_latch)
						state_nxt = fsc_pkg::FSC_ST_WDATA;
					else if (byte_in == `FSC_OP_WR_ANY && write_enable_latch)
						state_nxt = fsc_pkg::FSC_ST_ADDR;
					else
						state_nxt = fsc_pkg::FSC_ST_IGNORE;
				end
				fsc_pkg::FSC_ST_ADDR: begin
					if (byte_cnt_r == 2'd2)
						state_nxt = is_any_r ? fsc_pkg::FSC_ST_READ : fsc_pkg::FSC_ST_WDATA;
				end
				fsc_pkg::FSC_ST_READ:   state_nxt = fsc_pkg::FSC_ST_READ;
				fsc_pkg::FSC_ST_WDATA:  state_nxt = fsc_pkg::FSC_ST_WDATA;
				fsc_pkg::FSC_ST_IGNORE: state_nxt = fsc_pkg::FSC_ST_IGNORE;
				default:                state_nxt = fsc_pkg::FSC_ST_IGNORE;
			endcase
		end
	end

	// Frame sequencing
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			state_r    <= fsc_pkg::FSC_ST_CMD;
			bit_cnt_r  <= 3'd0;
			shift_in_r <= 7'h00;
			byte_cnt_r <= 2'd0;
		end else if (cs_start || cs_n_s) begin
			state_r    <= fsc_pkg::FSC_ST_CMD;
			bit_cnt_r  <= 3'd0;
			byte_cnt_r <= 2'd0;
		end else if (sck_rise) begin
			state_r    <= state_nxt;
			bit_cnt_r  <= bit_cnt_r + 3'd1;
			shift_in_r <= byte_in[6:0];
			if (byte_done)
				byte_cnt_r <= (state_r == state_nxt) ? byte_cnt_r + 2'd1 : 2'd0;
		end
	end

	// Command kind, address and write data capture
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			is_any_r   <= 1'b0;
			addr_r     <= 24'h000000;
			data0_r    <= 8'h00;
			data1_r    <= 8'h00;
			data_cnt_r <= 2'd0;
		end else if (cs_start) begin
			data_cnt_r <= 2'd0;
		end else if (byte_done) begin
			if (state_r == fsc_pkg::FSC_ST_CMD)
				is_any_r <= (byte_in == `FSC_OP_RD_ANY);
			if (state_r == fsc_pkg::FSC_ST_CMD && byte_in == `FSC_OP_WR_ANY)
				is_any_r <= 1'b0;
			if (state_r == fsc_pkg::FSC_ST_ADDR)
				addr_r <= addr_full;
			if (state_r == fsc_pkg::FSC_ST_WDATA) begin
				if (data_cnt_r == 2'd0)
					data0_r <= byte_in;
				if (data_cnt_r == 2'd1)
					data1_r <= byte_in;
				if (data_cnt_r != 2'd3)
					data_cnt_r <= data_cnt_r + 2'd1;
			end
		end
	end

	// Write-any-register flag: remembered separately from the read flag
	logic wr_any_r;
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst)
			wr_any_r <= 1'b0;
		else if (byte_done && state_r == fsc_pkg::FSC_ST_CMD)
			wr_any_r <= (byte_in == `FSC_OP_WR_ANY);
	end

	// Read data: loaded on the last rising edge of a byte, shifted on falls
	wire load_read = byte_done && (state_nxt == fsc_pkg::FSC_ST_READ);
	wire [7:0] load_img =
		(state_r == fsc_pkg::FSC_ST_CMD)  ? sr2_img :
		(state_r == fsc_pkg::FSC_ST_ADDR) ? any_img_new : repeat_img;

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			out_shift_r <= 8'h00;
			so_out      <= 1'b0;
			so_oe       <= 1'b0;
		end else if (cs_n_s) begin
			so_oe       <= 1'b0;
		end else if (load_read) begin
			out_shift_r <= load_img;
		end else if (sck_fall && state_r == fsc_pkg::FSC_ST_READ) begin
			so_out      <= out_shift_r[7];
			so_oe       <= 1'b1;
			out_shift_r <= {out_shift_r[6:0], 1'b0};
		end
	end

	// Commit decode at end of frame
	// A write-registers frame with a single data byte touches only the protect bits
	wire wr_frame    = cs_end && (state_r == fsc_pkg::FSC_ST_WDATA) && (data_cnt_r != 2'd0);
	wire wregs_frame = wr_frame && !wr_any_r;
	wire wany_frame  = wr_frame && wr_any_r;
	wire wr_sr1      = wregs_frame || (wany_frame && addr_r == `FSC_ADDR_STAT1);
	wire wr_cr1      = (wregs_frame && data_cnt_r >= 2'd2) ||
		(wany_frame && addr_r == `FSC_ADDR_CFG1);
	wire [7:0] cr1_data = wany_frame ? data0_r : data1_r;
	wire [2:0] bp_data  = data0_r[`FSC_SR1_BP_HI:`FSC_SR1_BP_LO];

	// Erase-result capture; writes never reach the status register
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst)
			erase_result_r <= 1'b0;
		else if (erase_check_done)
			erase_result_r <= erase_check_pass;
	end

	// Configuration register; one-time bits only ever gain ones
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			tbprot_r <= 1'b0;
			bpnv_r   <= 1'b0;
			tbparm_r <= 1'b0;
			quad_r   <= 1'b0;
		end else if (wr_cr1) begin
			tbprot_r <= tbprot_r | cr1_data[`FSC_CR1_TBPROT];
			bpnv_r   <= bpnv_r | cr1_data[`FSC_CR1_BPNV];
			tbparm_r <= tbparm_r | cr1_data[`FSC_CR1_TBPARM];
			quad_r   <= cr1_data[`FSC_CR1_QUAD];
		end
	end

	// Block-protect copies; volatile copy loads from the stored copy after reset
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			bp_v_r      <= `FSC_BP_RESET;
			bp_nv_r     <= `FSC_BP_RESET;
			init_done_r <= 1'b0;
		end else if (!init_done_r) begin
			bp_v_r      <= bp_nv_r;
			init_done_r <= 1'b1;
		end else if (wr_sr1) begin
			bp_v_r <= bp_data;
			if (!bpnv_r)
				bp_nv_r <= bp_data;
		end
	end

	// One-cycle pulse so the core can clear its write-enable latch
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst)
			reg_write_done <= 1'b0;
		else
			reg_write_done <= wr_sr1 | wr_cr1;
	end

	// Protected portion in sixty-fourths: 1/64, 1/32 ... 1/2, whole
	wire [2:0] bp_sel = bpnv_r ? bp_v_r : bp_nv_r;
	wire [6:0] portion =
		(bp_sel == 3'd0) ? 7'h00 :
		(bp_sel == 3'd7) ? `FSC_WHOLE_64THS :
		7'(7'h01 << (bp_sel - 3'd1));

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			protected_64ths     <= 7'h00;
			protect_from_bottom <= 1'b0;
		end else begin
			protected_64ths     <= portion;
			protect_from_bottom <= tbprot_r;
		end
	end

	// Configuration outputs straight from flip-flops; freeze default tied to 0
	assign protect_start_otp      = tbprot_r;
	assign protect_volatility_otp = bpnv_r;
	assign param_sector_place_otp = tbparm_r;
	assign wide_io_default        = quad_r;
	assign freeze_default         = 1'b0;
	assign block_protect_bits     = bp_v_r;
	assign block_protect_nv_bits  = bp_nv_r;

endmodule

// [verification/fsc_regs_sva.sv]
/* Checker on the ports of fsc_regs, bound at the foot of this file.
   Assumes one mclk domain and the active-low asynchronous nrst. */
`timescale 1ns/1ps

module fsc_regs_chk (
	// Clock, reset and serial pins
	input wire logic       mclk,
	input wire logic       nrst,
	input wire logic       cs_n,
	input wire logic       so_oe,
	// Configuration outputs
	input wire logic       protect_start_otp,
	input wire logic       protect_volatility_otp,
	input wire logic       param_sector_place_otp,
	input wire logic       wide_io_default,
	input wire logic       freeze_default,
	input wire logic [2:0] block_protect_bits,
	input wire logic [2:0] block_protect_nv_bits,
	input wire logic [6:0] protected_64ths,
	input wire logic       protect_from_bottom,
	input wire logic       reg_write_done
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);

	wire logic [2:0] otp     = {protect_start_otp, protect_volatility_otp, param_sector_place_otp};
	wire logic [6:0] portion = (block_protect_bits == 3'h0) ? 7'h00 : 7'h01 << (block_protect_bits - 3'h1);

	a_freeze_zero: assert property (freeze_default == 1'b0) else $error("freeze default set");
	a_bottom_follow: assert property ($stable(protect_start_otp) |-> protect_from_bottom == protect_start_otp)
		else $error("protection side wrong");
	a_otp_sticky: assert property (($past(otp) & ~otp) == 3'h0) else $error("one-time bit cleared");
	a_portion_map: assert property ($stable(block_protect_bits) [*2] |-> protected_64ths == portion)
		else $error("protected portion wrong");
	a_nv_hold: assert property ($past(protect_volatility_otp) |-> $stable(block_protect_nv_bits))
		else $error("nv protect copy changed");
	a_done_pulse: assert property (reg_write_done |=> !reg_write_done) else $error("write done too long");
	a_done_framed: assert property (reg_write_done |-> cs_n) else $error("write done inside frame");
	a_so_quiet: assert property (cs_n [*4] |-> !so_oe) else $error("so driven while deselected");
	a_commit_flag: assert property ($changed({otp, wide_io_default, block_protect_nv_bits}) |-> ##[0:2] reg_write_done)
		else $error("config changed without commit");

	c_write: cover property (reg_write_done);
	c_otp: cover property ($rose(protect_start_otp));
	c_read: cover property ($rose(so_oe));
endmodule

bind fsc_regs fsc_regs_chk u_chk (.mclk(mclk), .nrst(nrst), .cs_n(cs_n), .so_oe(so_oe),
	.protect_start_otp(protect_start_otp), .protect_volatility_otp(protect_volatility_otp),
	.param_sector_place_otp(param_sector_place_otp), .wide_io_default(wide_io_default),
	.freeze_default(freeze_default), .block_protect_bits(block_protect_bits),
	.block_protect_nv_bits(block_protect_nv_bits), .protected_64ths(protected_64ths),
	.protect_from_bottom(protect_from_bottom), .reg_write_done(reg_write_done));

// [verification/fsc_host.sv]
/* Serial host model: mode 0 frames, MSB first, sck idle low between frames.
   Assumes mclk at 40 MHz, so four mclk cycles make one sck half period. */
`timescale 1ns/1ps

module fsc_host (
	// Clock
	input wire logic mclk,
	// Serial pins
	output logic     sck,
	output logic     cs_n,
	output logic     si,
	input wire logic so_out
);
	initial begin
		sck = 1'b0;
		cs_n = 1'b1;
		si = 1'b0;
	end

	// Bits go out on the fall; so is taken late in the high phase, where it stands
	task automatic frame(input logic [47:0] tx, input int nbits, output logic [7:0] rd);
		rd = 8'h00;
		// Deselect gap of at least four mclk cycles before every frame
		repeat (4) @(posedge mclk);
		cs_n <= 1'b0;
		repeat (4) @(posedge mclk);
		for (int i = nbits - 1; i >= 0; i--) begin
			si <= tx[i];
			repeat (4) @(posedge mclk);
			sck <= 1'b1;
			repeat (4) @(posedge mclk);
			rd = {rd[6:0], so_out};
			sck <= 1'b0;
		end
		repeat (4) @(posedge mclk);
		cs_n <= 1'b1;
		si <= ~si;
	endtask
endmodule

// [verification/test_fsc_regs.sv]
/* Self-checking bench of fsc_regs driven through the serial host model.
   Assumes the checker is bound in from its own file. */
`timescale 1ns/1ps
`include "fsc_params.svh"
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin bad_count++; $display("Error %s expected %h seen %h", n, e, g); end end

module test_fsc_regs;
	logic        mclk = 1'b0;
	logic        nrst = 1'b0;
	logic        write_enable_latch = 1'b0;
	logic        erase_check_done = 1'b0;
	logic        erase_check_pass = 1'b0;
	logic        erase_suspended_bit = 1'b0;
	logic        program_suspended_bit = 1'b0;
	wire logic   sck, cs_n, si, so_out, so_oe, freeze_default, reg_write_done;
	wire logic   protect_start_otp, protect_volatility_otp, param_sector_place_otp, wide_io_default;
	wire logic   protect_from_bottom;
	wire logic [2:0] block_protect_bits, block_protect_nv_bits;
	wire logic [6:0] protected_64ths;
	int          bad_count = 0;
	int          num_checks = 0;
	int          seed = 72;
	logic [31:0] rnd;
	logic [7:0]  rdv;
	logic        ep, esus, psus;

	always #12.5 mclk = ~mclk;

	fsc_regs DUT (.mclk(mclk), .nrst(nrst), .sck(sck), .cs_n(cs_n), .si(si), .so_out(so_out), .so_oe(so_oe),
		.write_enable_latch(write_enable_latch), .erase_check_done(erase_check_done),
		.erase_check_pass(erase_check_pass), .erase_suspended_bit(erase_suspended_bit),
		.program_suspended_bit(program_suspended_bit), .protect_start_otp(protect_start_otp),
		.protect_volatility_otp(protect_volatility_otp), .param_sector_place_otp(param_sector_place_otp),
		.wide_io_default(wide_io_default), .freeze_default(freeze_default),
		.block_protect_bits(block_protect_bits), .block_protect_nv_bits(block_protect_nv_bits),
		.protected_64ths(protected_64ths), .protect_from_bottom(protect_from_bottom),
		.reg_write_done(reg_write_done));

	fsc_host host (.mclk(mclk), .sck(sck), .cs_n(cs_n), .si(si), .so_out(so_out));

	function automatic logic [7:0] sr2_exp(input logic p, input logic e, input logic s);
		return {5'h00, p & ~e & ~s, e, s};
	endfunction

	function automatic logic [6:0] portion_exp(input logic [2:0] b);
		return (b == 3'h0) ? 7'h00 : 7'h01 << (b - 3'h1);
	endfunction

	task automatic final_report();
		$display("Checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic rd_reg(input logic [7:0] op, input logic [23:0] addr, output logic [7:0] v);
		if (op == `FSC_OP_RD_SR2)
			host.frame({32'h0, op, 8'h00}, 16, v);
		else
			host.frame({op, addr, 8'h00}, 40, v);
	endtask

	task automatic wr_reg(input logic [39:0] tx, input int nbits, input logic ok);
		logic seen;
		seen = 1'b0;
		host.frame({8'h00, tx}, nbits, rdv);
		for (int i = 0; i < 24; i++) begin
			@(posedge mclk);
			if (reg_write_done === 1'b1)
				seen = 1'b1;
		end
		`CHK("write commit", ok, seen)
	endtask

	initial begin
		repeat (100000) @(posedge mclk);
		bad_count++;
		$display("Error watchdog expected end seen hang");
		final_report();
	end

	initial begin
		repeat (12) @(posedge mclk);
		nrst <= 1'b1;
		repeat (6) @(posedge mclk);
		rd_reg(`FSC_OP_RD_SR2, 24'h0, rdv);
		`CHK("status two reset", `FSC_SR2_RESET, rdv)
		`CHK("drive enable", 1'b1, so_oe)
		rd_reg(`FSC_OP_RD_ANY, `FSC_ADDR_CFG1, rdv);
		`CHK("config reset", `FSC_CR1_RESET, rdv)
		`CHK("freeze default", 1'b0, freeze_default)
		$display("Test reset done");
		wr_reg({`FSC_OP_WR_ANY, `FSC_ADDR_CFG1, 8'h02}, 40, 1'b0);
		`CHK("refused write", 1'b0, wide_io_default)
		write_enable_latch <= 1'b1;
		wr_reg({`FSC_OP_WR_ANY, `FSC_ADDR_STAT2, 8'hff}, 40, 1'b0);
		for (int k = 0; k < 12; k++) begin
			rnd = $random(seed);
			ep = rnd[0];
			esus = rnd[1] & rnd[2];
			psus = rnd[3] & rnd[4];
			erase_suspended_bit <= esus;
			program_suspended_bit <= psus;
			erase_check_done <= 1'b1;
			erase_check_pass <= ep;
			@(posedge mclk);
			erase_check_done <= 1'b0;
			rd_reg(k[0] ? `FSC_OP_RD_ANY : `FSC_OP_RD_SR2, `FSC_ADDR_STAT2, rdv);
			`CHK("status two", sr2_exp(ep, esus, psus), rdv)
		end
		$display("Test status done");
		wr_reg({`FSC_OP_WR_ANY, `FSC_ADDR_CFG1, 8'h02}, 40, 1'b1);
		`CHK("wide io default", 1'b1, wide_io_default)
		wr_reg({24'h0, `FSC_OP_WR_REGS, 8'h14}, 16, 1'b1);
		`CHK("protect nv", 3'h5, block_protect_nv_bits)
		`CHK("protect volatile", 3'h5, block_protect_bits)
		`CHK("portion", portion_exp(3'h5), protected_64ths)
		wr_reg({`FSC_OP_WR_ANY, `FSC_ADDR_CFG1, 8'hff}, 40, 1'b1);
		rd_reg(`FSC_OP_RD_ANY, `FSC_ADDR_CFG1, rdv);
		`CHK("config ones", 8'h2e, rdv)
		`CHK("from bottom", 1'b1, protect_from_bottom)
		`CHK("otp outputs", 3'h7, {protect_start_otp, protect_volatility_otp, param_sector_place_otp})
		wr_reg({16'h0, `FSC_OP_WR_REGS, 8'h00, 8'h00}, 24, 1'b1);
		rd_reg(`FSC_OP_RD_ANY, `FSC_ADDR_CFG1, rdv);
		`CHK("one-time kept", 8'h2c, rdv)
		`CHK("wide io cleared", 1'b0, wide_io_default)
		`CHK("otp outputs kept", 3'h7, {protect_start_otp, protect_volatility_otp, param_sector_place_otp})
		$display("Test config done");
		for (int b = 0; b < 8; b++) begin
			wr_reg({24'h0, `FSC_OP_WR_REGS, 3'h0, 3'(b), 2'h0}, 16, 1'b1);
			`CHK("portion", portion_exp(3'(b)), protected_64ths)
			`CHK("volatile protect", 3'(b), block_protect_bits)
			`CHK("nv kept", 3'h5, block_protect_nv_bits)
		end
		wr_reg({`FSC_OP_WR_ANY, `FSC_ADDR_STAT1, 8'h08}, 40, 1'b1);
		`CHK("any protect", 3'h2, block_protect_bits)
		`CHK("nv kept any", 3'h5, block_protect_nv_bits)
		rd_reg(`FSC_OP_RD_ANY, `FSC_ADDR_STAT1, rdv);
		`CHK("protect readback", 8'h08, rdv)
		$display("Test protect done");
		final_report();
	end
endmodule
